// file: src/lcc_defines.svh
// Constants for the link credit capability register bank.
// Assumes an APB slave with 32-bit data and byte addresses.
`ifndef LCC_DEFINES_SVH
`define LCC_DEFINES_SVH

// ****************************************************************
// Register map and field layout
// ****************************************************************
`define LCC_ADDR_SEND     12'h008
`define LCC_ADDR_RECEIVE  12'h00c
`define LCC_ADDR_CONTROL  12'h000
`define LCC_MEM_LSB       0
`define LCC_MEM_MSB       9
`define LCC_SNP_LSB       10
`define LCC_SNP_MSB       19
`define LCC_DAT_LSB       20
`define LCC_DAT_MSB       29
`define LCC_RSVD_LSB      30
`define LCC_RSVD_MSB      31
`define LCC_SCOPE_BIT     0
`define LCC_ZERO_COUNT    10'h000
`define LCC_ZERO_WORD     32'h0000_0000

`endif

// file: src/lcc_pkg.sv
// Types for the link credit capability register bank.
// Assumes lcc_defines.svh supplies the register map and field constants; the state encodings are set here.
package lcc_pkg;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lcc_apb_req_type;

    typedef struct packed {
        logic        requestAgent;
        logic        homeAgent;
        logic        subordinateAgent;
    } lcc_agents_type;

    typedef enum logic [1:0] {
        LCC_IDLE   = 2'b01,
        LCC_ANSWER = 2'b10
    } lcc_state_type;

endpackage

// file: src/lcc_link_credit_capability_regs.sv
// APB register bank advertising one link's send and receive credit limits.
// Assumes agent presence straps are static after reset and APB is synchronous to sys_clk.
`timescale 1ns/1ns
`include "lcc_defines.svh"

module lcc_link_credit_capability_regs #(
    parameter logic [9:0] MEM_SEND_CREDITS = 10'h040,
    parameter logic [9:0] SNP_SEND_CREDITS = 10'h020,
    parameter logic [9:0] DAT_SEND_CREDITS = 10'h040,
    parameter logic [9:0] MEM_RECV_CREDITS = 10'h040,
    parameter logic [9:0] SNP_RECV_CREDITS = 10'h020,
    parameter logic [9:0] DAT_RECV_CREDITS = 10'h040
) (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire lcc_pkg::lcc_apb_req_type apbReq,
    input  wire lcc_pkg::lcc_agents_type  agents,
    output logic                         pready,
    output logic                         pslverr,
    output logic [31:0]                  prdata,
    output logic                         creditScopeSelect
);
    import lcc_pkg::*;

    // ****************************************************************
    // Agent-gated field values
    // ****************************************************************
    logic [9:0]    memSend;
    logic [9:0]    snpSend;
    logic [9:0]    memRecv;
    logic [9:0]    snpRecv;
    logic [31:0]   sendWord;
    logic [31:0]   recvWord;

    // Zero a count when the agents that would use it are absent
    always_comb begin
        memSend = (agents.requestAgent | agents.homeAgent) ? MEM_SEND_CREDITS
                                                           : `LCC_ZERO_COUNT;
        snpSend = agents.homeAgent ? SNP_SEND_CREDITS : `LCC_ZERO_COUNT;
        memRecv = (agents.subordinateAgent | agents.homeAgent) ? MEM_RECV_CREDITS
                                                               : `LCC_ZERO_COUNT;
        snpRecv = agents.requestAgent ? SNP_RECV_CREDITS : `LCC_ZERO_COUNT;
    end

    // Pack the two capability words, reserved bits zero
    always_comb begin
        sendWord = `LCC_ZERO_WORD;
        sendWord[`LCC_MEM_MSB:`LCC_MEM_LSB] = memSend;
        sendWord[`LCC_SNP_MSB:`LCC_SNP_LSB] = snpSend;
        sendWord[`LCC_DAT_MSB:`LCC_DAT_LSB] = DAT_SEND_CREDITS;
        recvWord = `LCC_ZERO_WORD;
        recvWord[`LCC_MEM_MSB:`LCC_MEM_LSB] = memRecv;
        recvWord[`LCC_SNP_MSB:`LCC_SNP_LSB] = snpRecv;
        recvWord[`LCC_DAT_MSB:`LCC_DAT_LSB] = DAT_RECV_CREDITS;
    end

    // ****************************************************************
    // APB slave: one wait state, answers in the second access cycle
    // ****************************************************************
    lcc_state_type state;
    lcc_state_type next_state;
    logic          next_pready;
    logic          next_pslverr;
    logic [31:0]   next_prdata;
    logic          next_creditScopeSelect;
    logic          accessCycle;

    assign accessCycle = apbReq.psel & apbReq.penable;

    // Decode the access and build the answer
    always_comb begin
        next_state             = state;
        next_pready            = 1'b0;
        next_pslverr           = 1'b0;
        next_prdata            = `LCC_ZERO_WORD;
        next_creditScopeSelect = creditScopeSelect;
        unique case (state)
            LCC_IDLE: begin
                if (accessCycle) begin
                    next_state  = LCC_ANSWER;
                    next_pready = 1'b1;
                    unique case (apbReq.paddr)
                        `LCC_ADDR_SEND: begin
                            next_prdata = apbReq.pwrite ? `LCC_ZERO_WORD : sendWord;
                        end
                        `LCC_ADDR_RECEIVE: begin
                            next_prdata = apbReq.pwrite ? `LCC_ZERO_WORD : recvWord;
                        end
                        `LCC_ADDR_CONTROL: begin
                            if (apbReq.pwrite) begin
                                next_creditScopeSelect = apbReq.pwdata[`LCC_SCOPE_BIT];
                            end else begin
                                next_prdata[`LCC_SCOPE_BIT] = creditScopeSelect;
                            end
                        end
                        default: begin
                            next_pslverr = 1'b1;
                        end
                    endcase
                end
            end
            LCC_ANSWER: begin
                next_state = LCC_IDLE;
            end
            default: begin
                next_state = LCC_IDLE;
            end
        endcase
    end

    // Register the slave state and outputs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state             <= LCC_IDLE;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            prdata            <= `LCC_ZERO_WORD;
            creditScopeSelect <= 1'b0;
        end else begin
            state             <= next_state;
            pready            <= next_pready;
            pslverr           <= next_pslverr;
            prdata            <= next_prdata;
            creditScopeSelect <= next_creditScopeSelect;
        end
    end

    // ****************************************************************
    // Elaboration checks on the field layout
    // ****************************************************************
    // The snoop field must start right after the memory-request field
    if (`LCC_SNP_LSB != `LCC_MEM_MSB + 1) begin : g_bad_snp
        $error("snoop field must follow the memory-request field");
    end
    // The data field must start right after the snoop field
    if (`LCC_DAT_LSB != `LCC_SNP_MSB + 1) begin : g_bad_dat
        $error("data field must follow the snoop field");
    end
    // Reserved bits take what is left of the word
    if (`LCC_RSVD_LSB != `LCC_DAT_MSB + 1) begin : g_bad_rsvd
        $error("reserved bits must follow the data field");
    end
    // The word is 32 bits, so the reserved span must end at bit 31
    if (`LCC_RSVD_MSB != 31) begin : g_bad_top
        $error("reserved bits must end at the top of the word");
    end
    // The memory-request count field is ten bits, matching the parameter width
    if (`LCC_MEM_MSB - `LCC_MEM_LSB != 9) begin : g_bad_width
        $error("count fields must be ten bits wide");
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // An access taken by the idle slave, used by several properties
    logic idleAccess;
    assign idleAccess = (state == LCC_IDLE) & accessCycle;

    property p_send_read;
        @(posedge sys_clk) disable iff (!resetn)
        (state == LCC_IDLE && accessCycle && !apbReq.pwrite && apbReq.paddr == `LCC_ADDR_SEND)
        |=> pready && prdata == sendWord;
    endproperty
    a_send_read: assert property (p_send_read) else $error("send word read wrong");

    property p_recv_read;
        @(posedge sys_clk) disable iff (!resetn)
        (state == LCC_IDLE && accessCycle && !apbReq.pwrite && apbReq.paddr == `LCC_ADDR_RECEIVE)
        |=> pready && prdata == recvWord;
    endproperty
    a_recv_read: assert property (p_recv_read) else $error("receive word read wrong");

    property p_mem_send_zero;
        @(posedge sys_clk) disable iff (!resetn)
        !(agents.requestAgent | agents.homeAgent) |-> sendWord[9:0] == 10'h000;
    endproperty
    a_mem_send_zero: assert property (p_mem_send_zero) else $error("mem send not zero");

    property p_snp_send_zero;
        @(posedge sys_clk) disable iff (!resetn)
        !agents.homeAgent |-> sendWord[`LCC_SNP_MSB:`LCC_SNP_LSB] == `LCC_ZERO_COUNT;
    endproperty
    a_snp_send_zero: assert property (p_snp_send_zero) else $error("snoop send wrong");

    property p_mem_recv_zero;
        @(posedge sys_clk) disable iff (!resetn)
        !(agents.subordinateAgent | agents.homeAgent) |-> recvWord[9:0] == 10'h000;
    endproperty
    a_mem_recv_zero: assert property (p_mem_recv_zero) else $error("mem recv not zero");

    property p_snp_recv_zero;
        @(posedge sys_clk) disable iff (!resetn)
        !agents.requestAgent |-> recvWord[19:10] == 10'h000;
    endproperty
    a_snp_recv_zero: assert property (p_snp_recv_zero) else $error("snoop recv not zero");

    property p_data_fields;
        @(posedge sys_clk) disable iff (!resetn)
        sendWord[29:20] == DAT_SEND_CREDITS && recvWord[29:20] == DAT_RECV_CREDITS;
    endproperty
    a_data_fields: assert property (p_data_fields) else $error("data field wrong");

    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (!resetn)
        pready |-> prdata[`LCC_RSVD_MSB:`LCC_RSVD_LSB] == 2'b00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

    property p_scope_write;
        @(posedge sys_clk) disable iff (!resetn)
        (state == LCC_IDLE && accessCycle && apbReq.pwrite && apbReq.paddr == `LCC_ADDR_CONTROL)
        |=> creditScopeSelect == $past(apbReq.pwdata[0]) ##1 !pready;
    endproperty
    a_scope_write: assert property (p_scope_write) else $error("scope write lost");

    property p_pready_pulse;
        @(posedge sys_clk) disable iff (!resetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held");

    // ****************************************************************
    // Field values when the agents are present
    // ****************************************************************

    // Memory-request send count appears in full with a request or home agent
    property p_mem_send_full;
        @(posedge sys_clk) disable iff (!resetn)
        (agents.requestAgent | agents.homeAgent)
        |-> sendWord[`LCC_MEM_MSB:`LCC_MEM_LSB] == MEM_SEND_CREDITS;
    endproperty
    a_mem_send_full: assert property (p_mem_send_full) else $error("mem send wrong");

    // Snoop send count appears in full with a home agent
    property p_snp_send_full;
        @(posedge sys_clk) disable iff (!resetn)
        agents.homeAgent |-> sendWord[`LCC_SNP_MSB:`LCC_SNP_LSB] == SNP_SEND_CREDITS;
    endproperty
    a_snp_send_full: assert property (p_snp_send_full) else $error("snoop send wrong");

    // Memory-request receive count appears with a subordinate or home agent
    property p_mem_recv_full;
        @(posedge sys_clk) disable iff (!resetn)
        (agents.subordinateAgent | agents.homeAgent)
        |-> recvWord[`LCC_MEM_MSB:`LCC_MEM_LSB] == MEM_RECV_CREDITS;
    endproperty
    a_mem_recv_full: assert property (p_mem_recv_full) else $error("mem recv wrong");

    // Snoop receive count appears in full with a request agent
    property p_snp_recv_full;
        @(posedge sys_clk) disable iff (!resetn)
        agents.requestAgent |-> recvWord[`LCC_SNP_MSB:`LCC_SNP_LSB] == SNP_RECV_CREDITS;
    endproperty
    a_snp_recv_full: assert property (p_snp_recv_full) else $error("snoop recv wrong");

    // Data receive count is never gated
    property p_data_recv;
        @(posedge sys_clk) disable iff (!resetn)
        recvWord[`LCC_DAT_MSB:`LCC_DAT_LSB] == DAT_RECV_CREDITS;
    endproperty
    a_data_recv: assert property (p_data_recv) else $error("data recv wrong");

    // Reserved top bits of the send word stay zero
    property p_send_rsvd;
        @(posedge sys_clk) disable iff (!resetn)
        sendWord[`LCC_RSVD_MSB:`LCC_RSVD_LSB] == 2'b00;
    endproperty
    a_send_rsvd: assert property (p_send_rsvd) else $error("send reserved set");

    // Reserved top bits of the receive word stay zero
    property p_recv_rsvd;
        @(posedge sys_clk) disable iff (!resetn)
        recvWord[`LCC_RSVD_MSB:`LCC_RSVD_LSB] == 2'b00;
    endproperty
    a_recv_rsvd: assert property (p_recv_rsvd) else $error("recv reserved set");

    // ****************************************************************
    // Bus behaviour
    // ****************************************************************

    // A write to the send word is answered cleanly and returns nothing
    property p_send_write_ignored;
        @(posedge sys_clk) disable iff (!resetn)
        (idleAccess && apbReq.pwrite && apbReq.paddr == `LCC_ADDR_SEND)
        |=> pready && !pslverr && prdata == `LCC_ZERO_WORD;
    endproperty
    a_send_write_ignored: assert property (p_send_write_ignored) else $error("send write");

    // A write to the receive word is answered cleanly and returns nothing
    property p_recv_write_ignored;
        @(posedge sys_clk) disable iff (!resetn)
        (idleAccess && apbReq.pwrite && apbReq.paddr == `LCC_ADDR_RECEIVE)
        |=> pready && !pslverr && prdata == `LCC_ZERO_WORD;
    endproperty
    a_recv_write_ignored: assert property (p_recv_write_ignored) else $error("recv write");

    // Writes to the capability words leave the scope setting alone
    property p_cap_write_scope;
        @(posedge sys_clk) disable iff (!resetn)
        (idleAccess && apbReq.pwrite && apbReq.paddr != `LCC_ADDR_CONTROL)
        |=> creditScopeSelect == $past(creditScopeSelect);
    endproperty
    a_cap_write_scope: assert property (p_cap_write_scope) else $error("scope disturbed");

    // The scope setting moves only on a taken control write
    property p_scope_hold;
        @(posedge sys_clk) disable iff (!resetn)
        !(idleAccess && apbReq.pwrite && apbReq.paddr == `LCC_ADDR_CONTROL)
        |=> $stable(creditScopeSelect);
    endproperty
    a_scope_hold: assert property (p_scope_hold) else $error("scope changed alone");

    // A control read returns the scope setting in its bit
    property p_scope_read;
        @(posedge sys_clk) disable iff (!resetn)
        (idleAccess && !apbReq.pwrite && apbReq.paddr == `LCC_ADDR_CONTROL)
        |=> prdata[`LCC_SCOPE_BIT] == $past(creditScopeSelect);
    endproperty
    a_scope_read: assert property (p_scope_read) else $error("scope read wrong");

    // Outside an answer the read bus and error are quiet
    property p_quiet_between;
        @(posedge sys_clk) disable iff (!resetn)
        !pready |-> prdata == `LCC_ZERO_WORD && !pslverr;
    endproperty
    a_quiet_between: assert property (p_quiet_between) else $error("bus not quiet");

    // An unmapped address gets an error and no data
    property p_unmapped;
        @(posedge sys_clk) disable iff (!resetn)
        (idleAccess && !(apbReq.paddr inside {`LCC_ADDR_SEND, `LCC_ADDR_RECEIVE,
                                              `LCC_ADDR_CONTROL}))
        |=> pready && pslverr && prdata == `LCC_ZERO_WORD;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

    // Any write returns an empty read bus
    property p_write_no_data;
        @(posedge sys_clk) disable iff (!resetn)
        (idleAccess && apbReq.pwrite) |=> prdata == `LCC_ZERO_WORD;
    endproperty
    a_write_no_data: assert property (p_write_no_data) else $error("write returned data");

    // An answer only ever follows a taken access
    property p_ready_needs_access;
        @(posedge sys_clk) disable iff (!resetn)
        pready |-> $past(idleAccess);
    endproperty
    a_ready_needs_access: assert property (p_ready_needs_access) else $error("stray pready");

    // ****************************************************************
    // Covers
    // ****************************************************************
    c_send_read: cover property (p_send_read);
    c_send_write: cover property (p_send_write_ignored);
    c_recv_read: cover property (p_recv_read);
    c_scope_write: cover property (p_scope_write);
    c_error: cover property (@(posedge sys_clk) disable iff (!resetn) pslverr);

endmodule

// file: verification/lcc_link_credit_capability_regs_test.sv
// Self-checking bench for the link credit capability register bank.
// Assumes the bank answers each APB transfer with a registered one-cycle pready pulse.
`timescale 1ns/1ns
`include "lcc_defines.svh"

module lcc_link_credit_capability_regs_test;
    import lcc_pkg::*;

    // ****************************************************************
    // Signals and chosen credit counts (boundary values on purpose)
    // ****************************************************************
    localparam logic [9:0] MEM_SEND = 10'h3ff;
    localparam logic [9:0] SNP_SEND = 10'h001;
    localparam logic [9:0] DAT_SEND = 10'h2a5;
    localparam logic [9:0] MEM_RECV = 10'h155;
    localparam logic [9:0] SNP_RECV = 10'h3fe;
    localparam logic [9:0] DAT_RECV = 10'h000;
    logic            sys_clk;
    logic            resetn;
    lcc_apb_req_type apbReq;
    lcc_agents_type  agents;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            creditScopeSelect;
    logic [31:0]     readData;
    logic            errFlag;
    int              miscompares;
    int              checks;
    int              cycles;

    lcc_link_credit_capability_regs #(
        .MEM_SEND_CREDITS(MEM_SEND), .SNP_SEND_CREDITS(SNP_SEND), .DAT_SEND_CREDITS(DAT_SEND),
        .MEM_RECV_CREDITS(MEM_RECV), .SNP_RECV_CREDITS(SNP_RECV), .DAT_RECV_CREDITS(DAT_RECV)
    ) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .apbReq(apbReq), .agents(agents), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .creditScopeSelect(creditScopeSelect)
    );

    // Clock at 50 ns period
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    // ****************************************************************
    // Verdict, comparisons and bus cycles
    // ****************************************************************
    task automatic complete_run();
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic compare_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        bit gotReady;
        gotReady = 1'b0;
        @(posedge sys_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        // Look mid-cycle, where the registered answer has settled
        for (int n = 0; n < 16 && !gotReady; n++) begin
            @(negedge sys_clk);
            gotReady = (pready === 1'b1);
            readData = prdata;
            errFlag = pslverr;
        end
        // The next rising edge samples pready high; release only after it
        @(posedge sys_clk);
        apbReq <= '0;
        compare_bit(gotReady, 1'b1, "pready seen");
    endtask

    // Expected words worked out from the agent straps
    function automatic logic [31:0] exp_send(input lcc_agents_type ag);
        logic [9:0] mem;
        logic [9:0] snp;
        mem = (ag.requestAgent | ag.homeAgent) ? MEM_SEND : 10'h000;
        snp = ag.homeAgent ? SNP_SEND : 10'h000;
        return {2'b00, DAT_SEND, snp, mem};
    endfunction

    function automatic logic [31:0] exp_recv(input lcc_agents_type ag);
        logic [9:0] mem;
        logic [9:0] snp;
        mem = (ag.subordinateAgent | ag.homeAgent) ? MEM_RECV : 10'h000;
        snp = ag.requestAgent ? SNP_RECV : 10'h000;
        return {2'b00, DAT_RECV, snp, mem};
    endfunction

    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            $display("[FAIL] %0t run timed out", $time);
            complete_run();
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        apbReq = '0;
        agents = '0;
        miscompares = 0;
        checks = 0;
        cycles = 0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        compare_bit(creditScopeSelect, 1'b0, "scope at reset");
        // Every strap combination against both capability words
        for (int a = 0; a < 8; a++) begin
            agents <= lcc_agents_type'(a[2:0]);
            apb_xfer(1'b0, `LCC_ADDR_SEND, 32'h0000_0000);
            compare_word(readData, exp_send(agents), "send word");
            compare_bit(errFlag, 1'b0, "send error");
            apb_xfer(1'b0, `LCC_ADDR_RECEIVE, 32'h0000_0000);
            compare_word(readData, exp_recv(agents), "receive word");
        end
        // Writes to the capability words leave them unchanged
        apb_xfer(1'b1, `LCC_ADDR_SEND, 32'hffff_ffff);
        compare_bit(errFlag, 1'b0, "send write error");
        apb_xfer(1'b1, `LCC_ADDR_RECEIVE, 32'hffff_ffff);
        compare_bit(errFlag, 1'b0, "receive write error");
        // Both capability words read back unchanged after the writes
        apb_xfer(1'b0, `LCC_ADDR_SEND, 32'h0000_0000);
        compare_word(readData, exp_send(agents), "send after write");
        apb_xfer(1'b0, `LCC_ADDR_RECEIVE, 32'h0000_0000);
        compare_word(readData, exp_recv(agents), "receive after write");
        // Scope select set, survives an unmapped write, then cleared
        apb_xfer(1'b1, `LCC_ADDR_CONTROL, 32'h0000_0001);
        apb_xfer(1'b1, 12'h004, 32'h0000_0000);
        compare_bit(errFlag, 1'b1, "unmapped write error");
        apb_xfer(1'b0, `LCC_ADDR_CONTROL, 32'h0000_0000);
        compare_word(readData, 32'h0000_0001, "control read");
        compare_bit(creditScopeSelect, 1'b1, "scope port wide");
        apb_xfer(1'b1, `LCC_ADDR_CONTROL, 32'h0000_0000);
        apb_xfer(1'b0, 12'h010, 32'h0000_0000);
        compare_word({readData[31:1], errFlag}, 32'h0000_0001, "unmapped read");
        compare_bit(creditScopeSelect, 1'b0, "scope per link");
        complete_run();
    end
endmodule
